// [verilog/wut_pkg.sv]
// Constants shared by the wake-up interval timer files.
// Assumes a single 250 MHz system clock and an APB register port.
package wut_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] COUNT_ADDR = 8'h04;

  // Control/status field positions
  localparam int OVF_BIT   = 7;
  localparam int IEN_BIT   = 6;
  localparam int CAL_BIT   = 5;
  localparam int CLR_BIT   = 4;
  localparam int ON_BIT    = 3;
  localparam int SEL_MSB   = 2;
  localparam int SEL_LSB   = 0;
  localparam int SEL_W     = 3;
  localparam int REG_W     = 8;
  localparam int DATA_W    = 32;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RESET  = 3'h0;

  // Slow-clock cycle counts
  localparam int RC_BASE_CYCLES   = 4096;
  localparam int XTAL_BASE_CYCLES = 1024;
  localparam int RC_CAL_CYCLES    = 256;
  localparam int XTAL_CAL_CYCLES  = 64;
  localparam int CNT_W            = 19;

  // Bus answer state
  typedef enum logic [1:0] {
    WUT_IDLE = 2'b00,
    WUT_WAIT = 2'b01,
    WUT_DONE = 2'b11
  } wut_bus_state_t;

endpackage : wut_pkg

// [verilog/wut_sync.sv]
// Two-flop synchroniser for a pin level, with a rising-edge pulse.
// Assumes the input is asynchronous to mclk and slower than mclk/4.
`timescale 1ns/1ps
module wut_sync (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic pinIn,
  output logic      levelOut,
  output logic      risePulse
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // First stage feeds only the second stage; edges are taken later
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  assign levelOut  = stage2_reg;
  assign risePulse = stage2_reg & ~stage3_reg;

endmodule : wut_sync

// [verilog/wut_interval_counter.sv]
// Slow-clock cycle counter with overflow and calibration pulses.
// Assumes tick is a one-cycle mclk pulse per slow-clock rising edge.
`timescale 1ns/1ps
module wut_interval_counter #(
  parameter int RC_BASE   = wut_pkg::RC_BASE_CYCLES,
  parameter int XTAL_BASE = wut_pkg::XTAL_BASE_CYCLES,
  parameter int RC_CAL    = wut_pkg::RC_CAL_CYCLES,
  parameter int XTAL_CAL  = wut_pkg::XTAL_CAL_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        tick,
  input  wire logic                        clear,
  input  wire logic                        enable,
  input  wire logic                        xtalSel,
  input  wire logic [wut_pkg::SEL_W-1:0]   intervalSel,
  output logic      [wut_pkg::CNT_W-1:0]   count_reg,
  output logic                             ovfPulse_reg,
  output logic                             calPulse_reg
);

  logic [wut_pkg::CNT_W-1:0] lastCount;
  logic [wut_pkg::CNT_W-1:0] calMask;
  logic                      step;

  // Interval doubles per select code; terminal index is one below it
  always_comb begin
    lastCount = xtalSel ? wut_pkg::CNT_W'(XTAL_BASE) : wut_pkg::CNT_W'(RC_BASE);
    lastCount = (lastCount << intervalSel) - wut_pkg::CNT_W'(1);
    calMask   = xtalSel ? wut_pkg::CNT_W'(XTAL_CAL - 1) : wut_pkg::CNT_W'(RC_CAL - 1);
  end

  assign step = enable & tick & ~clear;

  // Clear restarts from zero; overflow wraps and keeps counting
  always_ff @(posedge mclk) begin
    if (srst || clear) begin
      count_reg <= '0;
    end else if (step) begin
      count_reg <= (count_reg == lastCount) ? '0 : count_reg + wut_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ovfPulse_reg <= 1'b0;
      calPulse_reg <= 1'b0;
    end else begin
      ovfPulse_reg <= step & (count_reg == lastCount);
      calPulse_reg <= step & ((count_reg & calMask) == calMask);
    end
  end

endmodule : wut_interval_counter

// [verilog/wut_timer.sv]
// Wake-up interval timer: APB register, flags and interrupt request.
// Assumes the slow clock arrives as a pin, source choice is made outside,
// and the CPU supplies its global enable and a vector-taken pulse.
//
// How it works
// - Count slow RC or crystal clock ticks
// - Three-bit select doubles interval per code
// - Overflow sets the overflow flag bit 7
// - Vector execution clears the overflow flag
// - Writing one clears overflow; zero keeps
// - Interrupt needs global enable, enable, flag
// - Calibration flag every 256 or 64 ticks
// - Writing one clears the calibration flag
// - Counter clear bit restarts; reads zero
// - Enable bit runs or stops the timer
`timescale 1ns/1ps
module wut_timer #(
  parameter int RC_BASE   = wut_pkg::RC_BASE_CYCLES,
  parameter int XTAL_BASE = wut_pkg::XTAL_BASE_CYCLES,
  parameter int RC_CAL    = wut_pkg::RC_CAL_CYCLES,
  parameter int XTAL_CAL  = wut_pkg::XTAL_CAL_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [wut_pkg::DATA_W-1:0]    pwdata,
  output logic      [wut_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          slowClkPin,
  input  wire logic                          xtalSourcePin,
  input  wire logic                          cpuIntEnable,
  input  wire logic                          vectorTaken,
  output logic                               wakeIrq
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (RC_BASE < 2 || XTAL_BASE < 2 || (RC_BASE << 7) > (1 << wut_pkg::CNT_W)
      || (XTAL_BASE << 7) > (1 << wut_pkg::CNT_W)) begin : g_bad_base
    $error("Interval base does not fit the counter");
  end
  if ((RC_CAL & (RC_CAL - 1)) != 0 || (XTAL_CAL & (XTAL_CAL - 1)) != 0
      || RC_CAL > RC_BASE || XTAL_CAL > XTAL_BASE) begin : g_bad_cal
    $error("Calibration period must be a power of two within the base");
  end
  if ((RC_BASE & (RC_BASE - 1)) != 0 || (XTAL_BASE & (XTAL_BASE - 1)) != 0) begin : g_base_pow2
    // Calibration pulses only stay periodic across a wrap on power-of-two bases
    $error("Interval base must be a power of two");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  wut_pkg::wut_bus_state_t          busState_reg;
  wut_pkg::wut_bus_state_t          busState_next;
  logic [wut_pkg::DATA_W-1:0]       prdata_reg;
  logic                             pslverr_reg;
  logic                             pready_reg;
  logic                             ovfFlag_reg;
  logic                             irqEn_reg;
  logic                             calFlag_reg;
  logic                             timerOn_reg;
  logic [wut_pkg::SEL_W-1:0]        sel_reg;
  logic                             wakeIrq_reg;
  logic                             slowTick;
  logic                             xtalSel;
  logic [wut_pkg::CNT_W-1:0]        count;
  logic                             ovfPulse;
  logic                             calPulse;
  logic                             accessDone;
  logic                             ctrlWrite;
  logic                             counterClear;
  logic [wut_pkg::REG_W-1:0]        ctrlView;

  function automatic logic addrMapped(input logic [7:0] addr);
    addrMapped = (addr == wut_pkg::CTRL_ADDR) || (addr == wut_pkg::COUNT_ADDR);
  endfunction : addrMapped

  function automatic logic isCtrl(input logic [7:0] addr);
    isCtrl = (addr == wut_pkg::CTRL_ADDR);
  endfunction : isCtrl

  ////////////////////////////////////////////////////////////////////////
  // Slow clock and source pins

  // Slow clock is sampled as data, so it must stay well below mclk/4
  wut_sync u_slow_sync (
    .mclk      (mclk),
    .srst      (srst),
    .pinIn     (slowClkPin),
    .levelOut  (),
    .risePulse (slowTick)
  );

  wut_sync u_src_sync (
    .mclk      (mclk),
    .srst      (srst),
    .pinIn     (xtalSourcePin),
    .levelOut  (xtalSel),
    .risePulse ()
  );

  wut_interval_counter #(
    .RC_BASE   (RC_BASE),
    .XTAL_BASE (XTAL_BASE),
    .RC_CAL    (RC_CAL),
    .XTAL_CAL  (XTAL_CAL)
  ) u_counter (
    .mclk         (mclk),
    .srst         (srst),
    .tick         (slowTick),
    .clear        (counterClear),
    .enable       (timerOn_reg),
    .xtalSel      (xtalSel),
    .intervalSel  (sel_reg),
    .count_reg    (count),
    .ovfPulse_reg (ovfPulse),
    .calPulse_reg (calPulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered

  always_comb begin
    busState_next = busState_reg;
    case (busState_reg)
      wut_pkg::WUT_IDLE: begin
        if (psel && !penable) begin
          busState_next = wut_pkg::WUT_WAIT;
        end
      end
      wut_pkg::WUT_WAIT: begin
        if (psel && penable) begin
          busState_next = wut_pkg::WUT_DONE;
        end
      end
      wut_pkg::WUT_DONE: begin
        busState_next = wut_pkg::WUT_IDLE;
      end
      default: begin
        busState_next = wut_pkg::WUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      busState_reg <= wut_pkg::WUT_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // A transfer completes at the edge where the master sees pready
  assign accessDone   = (busState_reg == wut_pkg::WUT_DONE) && psel && penable;
  assign ctrlWrite    = accessDone && pwrite && isCtrl(paddr);
  assign counterClear = ctrlWrite && pwdata[wut_pkg::CLR_BIT];

  assign ctrlView = {ovfFlag_reg, irqEn_reg, calFlag_reg, 1'b0, timerOn_reg, sel_reg};

  // Ready is registered with the data so the port comes straight from a flip-flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else if (busState_next == wut_pkg::WUT_DONE) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addrMapped(paddr);
      if (pwrite || !addrMapped(paddr)) begin
        prdata_reg <= '0;
      end else if (isCtrl(paddr)) begin
        prdata_reg <= {{(wut_pkg::DATA_W - wut_pkg::REG_W){1'b0}}, ctrlView};
      end else begin
        prdata_reg <= {{(wut_pkg::DATA_W - wut_pkg::CNT_W){1'b0}}, count};
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqEn_reg   <= wut_pkg::CTRL_RESET[wut_pkg::IEN_BIT];
      timerOn_reg <= wut_pkg::CTRL_RESET[wut_pkg::ON_BIT];
      sel_reg     <= wut_pkg::SEL_RESET;
    end else if (ctrlWrite) begin
      irqEn_reg   <= pwdata[wut_pkg::IEN_BIT];
      timerOn_reg <= pwdata[wut_pkg::ON_BIT];
      sel_reg     <= pwdata[wut_pkg::SEL_MSB:wut_pkg::SEL_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins

  always_ff @(posedge mclk) begin
    if (srst) begin
      ovfFlag_reg <= wut_pkg::CTRL_RESET[wut_pkg::OVF_BIT];
    end else if (ovfPulse) begin
      ovfFlag_reg <= 1'b1;
    end else if (vectorTaken) begin
      ovfFlag_reg <= 1'b0;
    end else if (ctrlWrite && pwdata[wut_pkg::OVF_BIT]) begin
      ovfFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      calFlag_reg <= wut_pkg::CTRL_RESET[wut_pkg::CAL_BIT];
    end else if (calPulse) begin
      calFlag_reg <= 1'b1;
    end else if (ctrlWrite && pwdata[wut_pkg::CAL_BIT]) begin
      calFlag_reg <= 1'b0;
    end
  end

  // Request follows the flag one cycle late so the output is registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeIrq_reg <= 1'b0;
    end else begin
      wakeIrq_reg <= cpuIntEnable && irqEn_reg && ovfFlag_reg;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign wakeIrq = wakeIrq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Flags and request
  a_ovf_sets_flag: assert property (
    ovfPulse |=> ovfFlag_reg)
    else $error("Overflow did not set the flag");

  a_ovf_single: assert property (
    ovfPulse |=> !ovfPulse)
    else $error("Overflow pulse lasted more than one cycle");

  a_vector_clears: assert property (
    vectorTaken && !ovfPulse |=> !ovfFlag_reg)
    else $error("Vector did not clear the overflow flag");

  a_zero_keeps_flag: assert property (
    ctrlWrite && !pwdata[wut_pkg::OVF_BIT] && !vectorTaken && ovfFlag_reg |=> ovfFlag_reg)
    else $error("Writing zero changed the overflow flag");

  a_irq_gating: assert property (
    wakeIrq == $past(cpuIntEnable && irqEn_reg && ovfFlag_reg))
    else $error("Interrupt request not gated by enables and flag");

  a_irq_no_global: assert property (
    !cpuIntEnable |=> !wakeIrq)
    else $error("Interrupt request without global enable");

  a_irq_flag_low: assert property (
    !ovfFlag_reg |=> !wakeIrq)
    else $error("Interrupt request without overflow flag");

  a_calib_period: assert property (
    calPulse |-> (int'(count) % ($past(xtalSel) ? XTAL_CAL : RC_CAL)) == 0)
    else $error("Calibration pulse off its period");

  a_cal_sets_flag: assert property (
    calPulse |=> calFlag_reg)
    else $error("Calibration pulse did not set the flag");

  a_calib_w1c: assert property (
    ctrlWrite && pwdata[wut_pkg::CAL_BIT] && !calPulse |=> !calFlag_reg)
    else $error("Writing one did not clear the calibration flag");

  // Counter
  a_clear_restarts: assert property (
    counterClear |=> count == '0 ##1 count <= wut_pkg::CNT_W'(1))
    else $error("Counter clear did not restart the count");

  a_clear_no_pulse: assert property (
    counterClear |=> !ovfPulse && !calPulse)
    else $error("Counter clear let a pulse through");

  a_clear_reads_zero: assert property (
    pready && !pwrite && isCtrl(paddr) |-> !prdata[wut_pkg::CLR_BIT])
    else $error("Counter clear bit read back as one");

  a_off_holds: assert property (
    !timerOn_reg && !counterClear |=> $stable(count))
    else $error("Counter moved while disabled");

  a_on_follows_write: assert property (
    ctrlWrite |=> timerOn_reg == $past(pwdata[wut_pkg::ON_BIT]))
    else $error("Enable bit did not follow the write");

  a_pulse_needs_on: assert property (
    (ovfPulse || calPulse) |-> $past(timerOn_reg))
    else $error("Pulse raised while the timer was off");

  // A step always changes the count: the terminal index is never zero
  a_tick_moves: assert property (
    timerOn_reg && slowTick && !counterClear |=> count != $past(count))
    else $error("Enabled tick did not advance the counter");

  a_wrap_zero: assert property (
    ovfPulse |-> count == '0)
    else $error("Counter did not wrap to zero on overflow");

  // Interval length
  a_interval_first: assert property (
    ovfPulse && sel_reg == 3'h0 && !$past(xtalSel) && $stable(sel_reg) |-> $past(count) == wut_pkg::CNT_W'(RC_BASE - 1))
    else $error("Shortest interval length wrong");

  a_sel_follows_write: assert property (
    ctrlWrite |=> sel_reg == $past(pwdata[wut_pkg::SEL_MSB:wut_pkg::SEL_LSB]))
    else $error("Interval select did not follow the write");

  c_overflow_irq: cover property (ovfPulse ##[1:3] wakeIrq);
  c_calib_clear:  cover property (calFlag_reg ##[1:50] !calFlag_reg);
  c_unmapped:     cover property (pready && pslverr);
  c_set_vs_clear: cover property (ovfPulse && vectorTaken);
  c_calib_set:    cover property (calPulse ##1 calFlag_reg);

endmodule : wut_timer

// [bench/wut_timer_tb.sv]
// Self-checking bench for the wake-up interval timer, driven over APB.
// Assumes shortened counts and the one-wait-state APB answer of the design.
`timescale 1ns/1ps
module wut_timer_tb;
  localparam int RcB   = 16;
  localparam int XtB   = 8;
  localparam int RcC   = 4;
  localparam int XtC   = 2;
  localparam int LIMIT = 90000;

  logic        mclk, srst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, wakeIrq;
  logic        slowClkPin, xtalSourcePin, cpuIntEnable, vectorTaken;
  int          errors, nTests, cycles, base, cal;

  wut_timer #(.RC_BASE(RcB), .XTAL_BASE(XtB), .RC_CAL(RcC), .XTAL_CAL(XtC)) dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slowClkPin(slowClkPin), .xtalSourcePin(xtalSourcePin), .cpuIntEnable(cpuIntEnable),
    .vectorTaken(vectorTaken), .wakeIrq(wakeIrq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // A hang anywhere ends in the same report
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdc

  // Slow edges spaced 9 mclk apart, well under the mclk/4 limit
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      slowClkPin <= 1'b1;
      repeat (4) @(posedge mclk);
      slowClkPin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : tick

  task automatic pulseVector();
    @(posedge mclk);
    vectorTaken <= 1'b1;
    @(posedge mclk);
    vectorTaken <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : pulseVector

  task automatic summarize();
    if (errors == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, slowClkPin, xtalSourcePin, cpuIntEnable, vectorTaken} <= 7'h00;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    errors = 0;
    nTests = 0;
    cycles = 0;
    srst <= 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rdc("ctrl reset", wut_pkg::CTRL_ADDR, 32'h00);
    rdc("unmapped data", 8'h08, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    wr(wut_pkg::CTRL_ADDR, 8'h18);
    rdc("clear reads zero", wut_pkg::CTRL_ADDR, 32'h08);
    tick(RcC - 1);
    rdc("count running", wut_pkg::COUNT_ADDR, 32'(RcC - 1));
    rdc("cal early", wut_pkg::CTRL_ADDR, 32'h08);
    tick(1);
    rdc("cal set", wut_pkg::CTRL_ADDR, 32'h28);
    wr(wut_pkg::CTRL_ADDR, 8'h28);
    rdc("cal cleared", wut_pkg::CTRL_ADDR, 32'h08);
    tick(RcB - RcC - 1);
    rdc("ovf early", wut_pkg::CTRL_ADDR, 32'h28);
    tick(1);
    rdc("ovf set", wut_pkg::CTRL_ADDR, 32'hA8);
    rdc("count wrapped", wut_pkg::COUNT_ADDR, 32'h0);
    check("irq no enable", 32'(wakeIrq), 32'h0);
    wr(wut_pkg::CTRL_ADDR, 8'h48);
    rdc("ovf kept on zero", wut_pkg::CTRL_ADDR, 32'hE8);
    check("irq no global", 32'(wakeIrq), 32'h0);
    cpuIntEnable <= 1'b1;
    repeat (3) @(posedge mclk);
    check("irq raised", 32'(wakeIrq), 32'h1);
    pulseVector();
    check("irq after vector", 32'(wakeIrq), 32'h0);
    rdc("ovf vector clear", wut_pkg::CTRL_ADDR, 32'h68);
    tick(RcB);
    check("irq repeats", 32'(wakeIrq), 32'h1);
    wr(wut_pkg::CTRL_ADDR, 8'hC8);
    rdc("ovf write clear", wut_pkg::CTRL_ADDR, 32'h68);
    check("irq dropped", 32'(wakeIrq), 32'h0);
    tick(3);
    wr(wut_pkg::CTRL_ADDR, 8'h20);
    tick(5);
    rdc("count held", wut_pkg::COUNT_ADDR, 32'h3);
    wr(wut_pkg::COUNT_ADDR, 8'h05);
    rdc("count read only", wut_pkg::COUNT_ADDR, 32'h3);
    // Every interval code on both sources; each restart also clears flags
    for (int s = 0; s < 2; s++) begin
      xtalSourcePin <= s[0];
      for (int k = 0; k < 8; k++) begin
        base = (s == 1 ? XtB : RcB) << k;
        cal = (s == 1) ? XtC : RcC;
        wr(wut_pkg::CTRL_ADDR, 8'hB8 | 8'(k));
        tick(cal - 1);
        apb(1'b0, wut_pkg::CTRL_ADDR, 32'h0);
        check("cal before period", 32'(rd[5]), 32'h0);
        tick(1);
        apb(1'b0, wut_pkg::CTRL_ADDR, 32'h0);
        check("cal at period", 32'(rd[5]), 32'h1);
        tick(base - cal - 1);
        apb(1'b0, wut_pkg::CTRL_ADDR, 32'h0);
        check("ovf before interval", 32'(rd[7]), 32'h0);
        tick(1);
        apb(1'b0, wut_pkg::CTRL_ADDR, 32'h0);
        check("ovf at interval", 32'(rd[7]), 32'h1);
      end
    end
    summarize();
  end
endmodule : wut_timer_tb
